// ==== logic/run_source_select.sv ====
// run_source_select: picks the run command source and decodes run/stop/direction
// assumes: single clock clk_sys_i, async high reset; link commands arrive as levels
// assumes: frequency flags are levels
// Function
// - two-wire: neither or both means stop
// - source 01 takes terminal run commands
// - function 00 forward, 01 reverse
// - polarity 00 normally open, 01 inverts
// - running needs frequency command and run
// - three-wire starts on go rising edge
// - three-wire halt released stops running
// - halt input always sensed normally closed
// - halt assigned disables two-wire inputs
// - codes 20/21/22 go, halt, direction
// - source 03 takes link commands
// - source 04 takes option board commands
// - forced keypad overrides run and frequency
// - forced terminal overrides run and frequency
// - forced keypad/terminal pick frequency source
// - force change while running stops, needs rerun
// - forced keypad wins over forced terminal
// - unassigned functions read inactive
// - source 02 takes keypad run/stop keys
`timescale 1ns/1ps
module run_source_select (
    // clock, reset, enable
    input  wire logic                                    clk_sys_i,
    input  wire logic                                    reset_i,
    input  wire logic                                    clk_en_i,
    // terminal block
    input  wire logic [run_source_pkg::NUM_TERMINALS-1:0] terminal_raw_i,
    // configuration
    input  wire logic [7:0]  run_source_select_i,
    input  wire logic [7:0]  input_function_assign_i [run_source_pkg::NUM_TERMINALS],
    input  wire logic [7:0]  input_polarity_select_i [run_source_pkg::NUM_TERMINALS],
    // keypad
    input  wire logic                                    keypad_run_key_i,
    input  wire logic                                    keypad_stop_key_i,
    input  wire logic                                    keypad_dir_rev_i,
    // serial link commands
    input  wire logic                                    modbus_run_i,
    input  wire logic                                    modbus_dir_rev_i,
    // option board commands
    input  wire logic                                    option_run_i,
    input  wire logic                                    option_dir_rev_i,
    // frequency command presence per source
    input  wire logic                                    freq_present_i,
    input  wire logic                                    keypad_freq_present_i,
    input  wire logic                                    analog_freq_present_i,
    // status
    output logic                                         running_o,
    output logic                                         direction_rev_o,
    output logic                                         run_command_o,
    output logic                                         freq_from_keypad_o,
    output logic                                         freq_from_analog_o,
    output logic [1:0]                                   effective_source_o
);

    // ------------------------------------------------------------
    // terminal sensing
    // ------------------------------------------------------------
    // terminal paths run two cycles late
    terminal_bus_if tb ();   // decoded terminal functions

    terminal_sense u_sense (
        .clk_sys_i               (clk_sys_i),
        .reset_i                 (reset_i),
        .clk_en_i                (clk_en_i),
        .terminal_raw_i          (terminal_raw_i),
        .input_function_assign_i (input_function_assign_i),
        .input_polarity_select_i (input_polarity_select_i),
        .bus                     (tb.producer)
    );

    // ------------------------------------------------------------
    // effective source
    // ------------------------------------------------------------
    run_source_pkg::eff_source_e eff_src;   // after force inputs
    run_source_pkg::eff_source_e cfg_src;   // from run_source_select alone
    logic                        cfg_valid; // configured code is a known source

    // unknown codes fall back to terminal but with run blocked
    // so a bad setting never starts
    assign cfg_src =
        (run_source_select_i == run_source_pkg::SRC_KEYPAD) ? run_source_pkg::EFF_KEYPAD :
        (run_source_select_i == run_source_pkg::SRC_MODBUS) ? run_source_pkg::EFF_MODBUS :
        (run_source_select_i == run_source_pkg::SRC_OPTION) ? run_source_pkg::EFF_OPTION :
                                                              run_source_pkg::EFF_TERMINAL;

    assign cfg_valid = (run_source_select_i == run_source_pkg::SRC_TERMINAL) ||
                       (run_source_select_i == run_source_pkg::SRC_KEYPAD)   ||
                       (run_source_select_i == run_source_pkg::SRC_MODBUS)   ||
                       (run_source_select_i == run_source_pkg::SRC_OPTION);

    // keypad force checked first so it wins when both are on
    assign eff_src = tb.force_keypad   ? run_source_pkg::EFF_KEYPAD :
                     tb.force_terminal ? run_source_pkg::EFF_TERMINAL :
                                         cfg_src;

    logic src_valid;   // forced sources are always valid
    assign src_valid = tb.force_keypad | tb.force_terminal | cfg_valid;

    // ------------------------------------------------------------
    // frequency source
    // ------------------------------------------------------------
    // same priority as the run source
    logic freq_ok;     // frequency command present on the chosen source
    assign freq_ok = tb.force_keypad   ? keypad_freq_present_i :
                     tb.force_terminal ? analog_freq_present_i :
                                         freq_present_i;

    // ------------------------------------------------------------
    // two-wire decode
    // ------------------------------------------------------------
    logic two_fwd;   // forward only
    logic two_rev;   // reverse only
    logic two_wire;  // two-wire pair in use

    // any halt function means three-wire
    assign two_wire = ~tb.halt_assigned;
    assign two_fwd  = two_wire & tb.forward_run & ~tb.reverse_run;
    assign two_rev  = two_wire & tb.reverse_run & ~tb.forward_run;

    // ------------------------------------------------------------
    // level-style sources
    // ------------------------------------------------------------
    // link and option hand over levels
    logic level_run;   // level run request from link or option
    logic level_rev;   // its direction

    assign level_run = (eff_src == run_source_pkg::EFF_MODBUS) ? modbus_run_i : option_run_i;
    assign level_rev = (eff_src == run_source_pkg::EFF_MODBUS) ? modbus_dir_rev_i
                                                               : option_dir_rev_i;

    logic level_src;   // source is link or option
    assign level_src = (eff_src == run_source_pkg::EFF_MODBUS) ||
                       (eff_src == run_source_pkg::EFF_OPTION);

    // ------------------------------------------------------------
    // requested command, combinational
    // ------------------------------------------------------------
    logic want_run;    // a run is requested this cycle (level sources)
    logic want_rev;    // requested direction
    logic start_evt;   // a start event for edge sources
    logic stop_evt;    // an explicit stop for edge sources

    // defaults keep every output assigned
    always_comb begin
        want_run  = 1'b0;
        want_rev  = 1'b0;
        start_evt = 1'b0;
        stop_evt  = 1'b0;

        case (eff_src)
            run_source_pkg::EFF_TERMINAL: begin
                if (tb.halt_assigned) begin
                    // three-wire: edge starts, halt release stops
                    start_evt = tb.go_rise & tb.halt_hold;
                    stop_evt  = ~tb.halt_hold;
                    want_rev  = tb.direction_rev;
                    want_run  = 1'b1;
                end else begin
                    // plain levels
                    want_run  = two_fwd | two_rev;
                    want_rev  = two_rev;
                end
            end
            run_source_pkg::EFF_KEYPAD: begin
                // momentary keys; stop key wins over run key
                start_evt = keypad_run_key_i & ~keypad_stop_key_i;
                stop_evt  = keypad_stop_key_i;
                want_rev  = keypad_dir_rev_i;
                want_run  = 1'b1;
            end
            default: begin
                // run follows the level
                want_run  = level_src & level_run;
                want_rev  = level_rev;
            end
        endcase
    end

    // sources that latch on a start event instead of following a level
    // and hold the run in the state machine
    logic edge_src;
    assign edge_src = (eff_src == run_source_pkg::EFF_KEYPAD) ||
                      ((eff_src == run_source_pkg::EFF_TERMINAL) && tb.halt_assigned);

    // ------------------------------------------------------------
    // force change detect
    // ------------------------------------------------------------
    // one-cycle pulse on any force edge
    logic force_key_q;   // force inputs one cycle ago
    logic force_trm_q;
    logic force_change;

    assign force_change = (force_key_q != tb.force_keypad) ||
                          (force_trm_q != tb.force_terminal);

    // request seen this cycle that would keep or start a run
    logic request_on;
    assign request_on = edge_src ? (start_evt & ~stop_evt) : want_run;

    // ------------------------------------------------------------
    // run state machine
    // ------------------------------------------------------------
    run_source_pkg::run_state_e state_q, state_d;
    logic run_dir_q, run_dir_d;        // latched direction

    logic go_ok;                       // all start conditions met except the force check

    // nothing starts without frequency
    assign go_ok = src_valid & freq_ok & request_on;

    always_comb begin
        state_d   = state_q;
        run_dir_d = run_dir_q;

        case (state_q)
            run_source_pkg::ST_STOPPED: begin
                // needs a full start request
                if (go_ok && !force_change) begin
                    state_d   = want_rev ? run_source_pkg::ST_RUN_REV
                                         : run_source_pkg::ST_RUN_FWD;
                    run_dir_d = want_rev;
                end
            end
            run_source_pkg::ST_RUN_FWD,
            run_source_pkg::ST_RUN_REV: begin
                if (force_change) begin
                    state_d = run_source_pkg::ST_LOCKOUT;
                end else if (!src_valid || !freq_ok) begin
                    state_d = run_source_pkg::ST_STOPPED;
                end else if (edge_src) begin
                    if (stop_evt) begin
                        state_d = run_source_pkg::ST_STOPPED;
                    end else begin
                        // direction follows the live direction input
                        run_dir_d = want_rev;
                        state_d   = want_rev ? run_source_pkg::ST_RUN_REV
                                             : run_source_pkg::ST_RUN_FWD;
                    end
                end else if (!want_run) begin
                    state_d = run_source_pkg::ST_STOPPED;
                end else begin
                    run_dir_d = want_rev;
                    state_d   = want_rev ? run_source_pkg::ST_RUN_REV
                                         : run_source_pkg::ST_RUN_FWD;
                end
            end
            run_source_pkg::ST_LOCKOUT: begin
                // held until the run request goes away entirely
                if (edge_src ? stop_evt | ~start_evt : ~want_run) begin
                    state_d = run_source_pkg::ST_STOPPED;
                end
            end
            default: begin
                state_d = run_source_pkg::ST_STOPPED;
            end
        endcase
    end

    // state and force history, frozen by clock enable
    // force history resets low like the sync
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_q     <= run_source_pkg::ST_STOPPED;
            run_dir_q   <= 1'b0;
            force_key_q <= 1'b0;
            force_trm_q <= 1'b0;
        end else if (clk_en_i) begin
            state_q     <= state_d;
            run_dir_q   <= run_dir_d;
            force_key_q <= tb.force_keypad;
            force_trm_q <= tb.force_terminal;
        end
    end

    // ------------------------------------------------------------
    // status outputs, registered
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            running_o          <= 1'b0;
            direction_rev_o    <= 1'b0;
            run_command_o      <= 1'b0;
            freq_from_keypad_o <= 1'b0;
            freq_from_analog_o <= 1'b0;
            effective_source_o <= 2'h0;
        end else if (clk_en_i) begin
            running_o          <= (state_d == run_source_pkg::ST_RUN_FWD) ||
                                  (state_d == run_source_pkg::ST_RUN_REV);
            direction_rev_o    <= run_dir_d;
            run_command_o      <= request_on;
            freq_from_keypad_o <= tb.force_keypad;
            freq_from_analog_o <= tb.force_terminal & ~tb.force_keypad;
            effective_source_o <= eff_src;
        end
    end

endmodule

// ==== logic/run_source_pkg.sv ====
// run_source_pkg: constants and types shared by the run command source selector
// assumes: included first in compile order; no imports anywhere, names are scoped
package run_source_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_TERMINALS = 7;             // input terminals 1..7

    // ------------------------------------------------------------
    // run source codes
    // ------------------------------------------------------------
    localparam logic [7:0] SRC_TERMINAL = 8'h01;  // control terminals
    localparam logic [7:0] SRC_KEYPAD   = 8'h02;  // keypad run/stop keys
    localparam logic [7:0] SRC_MODBUS   = 8'h03;  // serial link
    localparam logic [7:0] SRC_OPTION   = 8'h04;  // option board

    // ------------------------------------------------------------
    // terminal function codes (decimal codes held as bytes)
    // ------------------------------------------------------------
    localparam logic [7:0] FN_FORWARD   = 8'h00;  // forward_run_input
    localparam logic [7:0] FN_REVERSE   = 8'h01;  // reverse_run_input
    localparam logic [7:0] FN_GO        = 8'h14;  // three_wire_go_pulse (20)
    localparam logic [7:0] FN_HALT      = 8'h15;  // three_wire_halt_hold (21)
    localparam logic [7:0] FN_DIR       = 8'h16;  // three_wire_direction (22)
    localparam logic [7:0] FN_FORCE_KEY = 8'h1F;  // forced_keypad_source (31)
    localparam logic [7:0] FN_FORCE_TRM = 8'h33;  // forced_terminal_source (51)

    // ------------------------------------------------------------
    // polarity codes
    // ------------------------------------------------------------
    localparam logic [7:0] POL_NO = 8'h00;        // normally open
    localparam logic [7:0] POL_NC = 8'h01;        // normally closed

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [NUM_TERMINALS-1:0] SYNC_RESET = '0;

    // effective source after forcing
    typedef enum logic [1:0] {
        EFF_TERMINAL,
        EFF_KEYPAD,
        EFF_MODBUS,
        EFF_OPTION
    } eff_source_e;

    // run state machine
    typedef enum logic [1:0] {
        ST_STOPPED,
        ST_RUN_FWD,
        ST_RUN_REV,
        ST_LOCKOUT
    } run_state_e;

endpackage

// ==== logic/terminal_bus_if.sv ====
// terminal_bus_if: decoded terminal functions passed from the sensing stage
// assumes: one clock domain; driven by terminal_sense, read by the top
`timescale 1ns/1ps
interface terminal_bus_if;
    logic forward_run;        // forward_run_input active
    logic reverse_run;        // reverse_run_input active
    logic go_level;           // three_wire_go_pulse level
    logic go_rise;            // three_wire_go_pulse rising edge
    logic halt_hold;          // three_wire_halt_hold active (closed)
    logic halt_assigned;      // some terminal carries the halt function
    logic direction_rev;      // three_wire_direction active
    logic force_keypad;       // forced_keypad_source active
    logic force_terminal;     // forced_terminal_source active

    modport producer (
        output forward_run, reverse_run, go_level, go_rise, halt_hold,
        output halt_assigned, direction_rev, force_keypad, force_terminal
    );
    modport consumer (
        input  forward_run, reverse_run, go_level, go_rise, halt_hold,
        input  halt_assigned, direction_rev, force_keypad, force_terminal
    );
endinterface

// ==== logic/terminal_sense.sv ====
// terminal_sense: synchronises terminals, applies polarity, maps functions
// assumes: terminal levels asynchronous to clk_sys_i; settings static-ish
`timescale 1ns/1ps
module terminal_sense (
    // clock, reset and enable
    input  wire logic                                    clk_sys_i,
    input  wire logic                                    reset_i,
    input  wire logic                                    clk_en_i,
    // raw terminals and per-terminal settings
    input  wire logic [run_source_pkg::NUM_TERMINALS-1:0] terminal_raw_i,
    input  wire logic [7:0]  input_function_assign_i [run_source_pkg::NUM_TERMINALS],
    input  wire logic [7:0]  input_polarity_select_i [run_source_pkg::NUM_TERMINALS],
    // decoded functions
    terminal_bus_if.producer                             bus
);

    // ------------------------------------------------------------
    // two-stage synchroniser
    // ------------------------------------------------------------
    logic [run_source_pkg::NUM_TERMINALS-1:0] meta_q;     // first stage, read by sync only
    logic [run_source_pkg::NUM_TERMINALS-1:0] sync_q;     // second stage
    logic                                     go_prev_q;  // go level one cycle ago

    // synchroniser chain, frozen by clock enable
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= run_source_pkg::SYNC_RESET;
            sync_q <= run_source_pkg::SYNC_RESET;
        end else if (clk_en_i) begin
            meta_q <= terminal_raw_i;
            sync_q <= meta_q;
        end
    end

    // ------------------------------------------------------------
    // polarity and function map
    // ------------------------------------------------------------
    logic [run_source_pkg::NUM_TERMINALS-1:0] closed;   // contact closed (raw sense)
    logic [run_source_pkg::NUM_TERMINALS-1:0] active;   // after polarity
    logic [run_source_pkg::NUM_TERMINALS-1:0] is_fw, is_rv, is_go, is_halt, is_dir;
    logic [run_source_pkg::NUM_TERMINALS-1:0] is_fk, is_ft;

    genvar t;
    generate
        for (t = 0; t < run_source_pkg::NUM_TERMINALS; t++) begin : g_term
            assign closed[t]  = sync_q[t];
            // normally closed inverts the sensed state; other codes act as open
            assign active[t]  = (input_polarity_select_i[t] == run_source_pkg::POL_NC)
                              ? ~closed[t] : closed[t];
            assign is_fw[t]   = input_function_assign_i[t] == run_source_pkg::FN_FORWARD;
            assign is_rv[t]   = input_function_assign_i[t] == run_source_pkg::FN_REVERSE;
            assign is_go[t]   = input_function_assign_i[t] == run_source_pkg::FN_GO;
            assign is_halt[t] = input_function_assign_i[t] == run_source_pkg::FN_HALT;
            assign is_dir[t]  = input_function_assign_i[t] == run_source_pkg::FN_DIR;
            assign is_fk[t]   = input_function_assign_i[t] == run_source_pkg::FN_FORCE_KEY;
            assign is_ft[t]   = input_function_assign_i[t] == run_source_pkg::FN_FORCE_TRM;
        end
    endgenerate

    // unassigned functions fall out as zero through the OR reduction
    assign bus.forward_run    = |(is_fw & active);
    assign bus.reverse_run    = |(is_rv & active);
    assign bus.go_level       = |(is_go & active);
    // halt always treated as NC: run allowed only while the contact is closed,
    // an open wire reads as stop whatever the polarity code says
    assign bus.halt_hold      = |(is_halt & closed);
    assign bus.halt_assigned  = |is_halt;
    assign bus.direction_rev  = |(is_dir & active);
    assign bus.force_keypad   = |(is_fk & active);
    assign bus.force_terminal = |(is_ft & active);

    // ------------------------------------------------------------
    // go edge detect on the synchronised value
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            go_prev_q <= 1'b0;
        end else if (clk_en_i) begin
            go_prev_q <= bus.go_level;
        end
    end

    assign bus.go_rise = bus.go_level & ~go_prev_q;

endmodule

// ==== testbench/run_source_select_chk.sv ====
// run_source_select_chk: port-level checks for the run source selector
// assumes: clk_en_i held high, so every clock edge is an enabled edge
`timescale 1ns/1ps
module run_source_select_chk (
    // clock, reset and status
    input wire logic       clk_sys_i, reset_i, running_o, freq_from_keypad_o, freq_from_analog_o,
    // command, frequency and source inputs
    input wire logic       modbus_run_i, option_run_i,
    input wire logic       freq_present_i, keypad_freq_present_i, analog_freq_present_i,
    input wire logic [7:0] run_source_select_i,
    input wire logic [1:0] effective_source_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // outputs are registered, so each cause sits one edge back
    AST_START_FREQ: assert property ($rose(running_o) |->
        (freq_from_keypad_o ? $past(keypad_freq_present_i) : freq_from_analog_o ?
        $past(analog_freq_present_i) : $past(freq_present_i)))
        else $error("start without frequency");
    AST_LINK_SRC: assert property (effective_source_o == 2'h2 |->
        $past(run_source_select_i) == 8'h03) else $error("bad link source");
    AST_OPTION_SRC: assert property (effective_source_o == 2'h3 |->
        $past(run_source_select_i) == 8'h04) else $error("bad option source");
    AST_KEYPAD_SRC: assert property (effective_source_o == 2'h1 && !freq_from_keypad_o |->
        $past(run_source_select_i) == 8'h02) else $error("bad keypad source");
    AST_LINK_RUN: assert property ($rose(running_o) && effective_source_o == 2'h2 |->
        $past(modbus_run_i)) else $error("link start without link run");
    AST_OPTION_RUN: assert property ($rose(running_o) && effective_source_o == 2'h3 |->
        $past(option_run_i)) else $error("option start without option run");
    AST_KEY_FREQ: assert property (freq_from_keypad_o |-> effective_source_o == 2'h1)
        else $error("keypad frequency off keypad source");
    AST_ANALOG_FREQ: assert property (freq_from_analog_o |->
        effective_source_o == 2'h0 && !freq_from_keypad_o) else $error("bad analog select");
endmodule
bind run_source_select run_source_select_chk u_run_source_select_chk (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .running_o(running_o),
    .freq_from_keypad_o(freq_from_keypad_o), .freq_from_analog_o(freq_from_analog_o),
    .modbus_run_i(modbus_run_i), .option_run_i(option_run_i), .freq_present_i(freq_present_i),
    .keypad_freq_present_i(keypad_freq_present_i), .analog_freq_present_i(analog_freq_present_i),
    .run_source_select_i(run_source_select_i), .effective_source_o(effective_source_o));

// ==== testbench/terminal_block.sv ====
// terminal_block: contact model for the seven control terminals
// assumes: contacts switch clean, no bounce reaches the synchroniser
`timescale 1ns/1ps
module terminal_block (
    input  wire logic [6:0] closed_i, // contact closed per terminal
    output logic [6:0]      raw_o     // wire level, closed reads high
);
    assign raw_o = closed_i;
endmodule

// ==== testbench/tb_run_source_select.sv ====
// tb_run_source_select: self-checking bench, expectations from the rules
// assumes: contacts and commands change at the falling edge; clk_en_i high
`timescale 1ns/1ps
module tb_run_source_select;
    logic       clk_sys_i = 0, reset_i = 1, kr = 0, ks = 0, mr = 0, orn = 0, fq = 1;
    logic       run, dir, rc, fk, fn;
    logic [1:0] eff;
    logic [6:0] closed = '0, raw;
    logic [7:0] sel = 8'h01, fa [7], pa [7];
    int         i, s, r, n_mismatch = 0, n_compared = 0;
    wire  [1:0] rd = {run, run & dir}; // direction only matters while running
    always #10 clk_sys_i = ~clk_sys_i;
    terminal_block u_terminal_block (.closed_i(closed), .raw_o(raw));
    run_source_select u_run_source_select (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .clk_en_i(1'b1), .terminal_raw_i(raw), .run_source_select_i(sel),
        .input_function_assign_i(fa), .input_polarity_select_i(pa), .keypad_run_key_i(kr),
        .keypad_stop_key_i(ks), .keypad_dir_rev_i(1'b0), .modbus_run_i(mr),
        .modbus_dir_rev_i(mr), .option_run_i(orn), .option_dir_rev_i(1'b0),
        .freq_present_i(fq), .keypad_freq_present_i(1'b1), .analog_freq_present_i(1'b1),
        .running_o(run), .direction_rev_o(dir), .run_command_o(rc),
        .freq_from_keypad_o(fk), .freq_from_analog_o(fn), .effective_source_o(eff));
    task automatic step(input int n); repeat (n) @(negedge clk_sys_i); endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // hang guard: a stuck run counts as a mismatch
    initial begin #100000; n_mismatch++; give_verdict(); end
    initial begin
        void'($urandom(32'h2B48));
        for (i = 0; i < 7; i++) begin
            fa[i] = 8'hFF;
            pa[i] = 8'h00;
        end
        fa[0] = 8'h00;
        fa[1] = 8'h01;
        step(8);
        reset_i = 0;
        closed[0] = 1;
        step(2); chk(rd, 2'b00);
        step(1); chk(rd, 2'b10);
        // all forward/reverse pairs, terminal 1 polarity drawn at random
        for (i = 0; i < 4; i++) begin
            r = $urandom % 2;
            pa[0] = {7'h0, r[0]};
            closed[1:0] = {i[1], i[0] ^ r[0]};
            step(4); chk(rd, {i[0] ^ i[1], i[1] & ~i[0]});
        end
        closed = 7'h01; pa[0] = 8'h00; fq = 0;
        step(4); chk({rc, run}, 2'b10);
        fq = 1; step(2); chk({rc, run}, 2'b11);
        // keypad, link and option sources with conflicting commands, then code 05
        for (s = 2; s < 6; s++) begin
            sel = s[7:0]; r = $urandom % 2; mr = r[0]; orn = ~r[0]; kr = 1;
            step(3); chk(eff, s[1:0] - 2'h1);
            chk(rd, s == 2 ? 2'b10 : s == 3 ? {r[0], r[0]} :
                s == 4 ? {~r[0], 1'b0} : 2'b00);
            if (s == 2) begin
                kr = 0; ks = 1; step(2); chk(rd, 2'b00); ks = 0;
            end
        end
        // three-wire: go on 1, halt on 2 set inverted, direction on 3, stray forward on 4
        sel = 8'h01; mr = 0; orn = 0; kr = 0;
        fa[0] = 8'h14; fa[1] = 8'h15; fa[2] = 8'h16; fa[3] = 8'h00; pa[1] = 8'h01;
        closed = 7'h09;
        step(4); chk(rd, 2'b00);
        closed[1] = 1; step(4); chk(rd, 2'b00);
        closed[0] = 0; step(3); closed[2:0] = 3'h7; step(4); chk(rd, 2'b11);
        closed[0] = 0; step(4); chk(rd, 2'b11);
        closed[1] = 0; step(4); chk(rd, 2'b00);
        // force inputs over a running link
        fa[4] = 8'h1F; fa[5] = 8'h33; sel = 8'h03; mr = 1;
        step(2); chk(rd, 2'b11);
        closed[5] = 1; step(4); chk(rd, 2'b00); chk({fk, fn}, 2'b01);
        chk(eff, 2'h0);
        closed[4] = 1; step(4); chk({fk, fn}, 2'b10); chk(eff, 2'h1);
        kr = 1; fq = 0; step(3); chk(rd, 2'b10);
        closed[5:4] = 2'b00; fq = 1; step(4); chk(rd, 2'b00);
        kr = 0; mr = 0; step(2); mr = 1; step(2); chk(rd, 2'b11);
        give_verdict();
    end
endmodule
